// ### rtl/time_engine_pkg.sv
// shared types and constants for the time engine output generators
package time_engine_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int HIZ_DELAY_NS = 8;
  localparam int HIZ_DELAY_RAW =
    (HIZ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_DELAY_CYCLES = (HIZ_DELAY_RAW < 1) ? 1 : HIZ_DELAY_RAW;
  localparam int HIZ_CNT_W = 4;

  localparam int DIV_W = 8;
  localparam int OUT_PHASES = 8;
  localparam int GEN_COUNT = 2;
  localparam int CMD_W = 22;
  localparam int GEN_FIFO_DEPTH = 16;
  localparam int DATA_W = 16;
  localparam int ACC_W = 5 * DATA_W;
  localparam int SEC_W = 48;
  localparam int NS_W = 30;
  localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3B9A_CA00;

  localparam logic [3:0] CODE_REPEAT = 4'h0;
  localparam logic [3:0] CODE_FRAC = 4'h1;
  localparam logic [3:0] CODE_REF = 4'h2;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] FORM_NONE = 2'h0;
  localparam logic [1:0] FORM_ABS = 2'h1;
  localparam logic [1:0] FORM_REL32 = 2'h2;
  localparam logic [2:0] WORDS_ABS = 3'h5;
  localparam logic [2:0] WORDS_REL32 = 3'h2;
  localparam logic [2:0] WORDS_REL16 = 3'h1;

  localparam int REP_N_LSB = 0;
  localparam int REP_N_W = 4;
  localparam int REP_M_LSB = 4;
  localparam int REP_M_W = 12;
  localparam int FRAC_M1_LSB = 8;
  localparam int FRAC_M2_LSB = 0;
  localparam int FRAC_M_W = 8;
  localparam int FRAC_SPAN = 4;
  localparam int FRAC_HALF = 2;

  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_CLOCK = 2'h1;
  localparam logic [1:0] SRC_GEN1 = 2'h2;
  localparam logic [1:0] SRC_GEN2 = 2'h3;

  typedef struct packed {
    logic stat;
    logic hiz;
    logic [3:0] code;
    logic [DATA_W-1:0] data;
  } cmd_word_t;

  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [NS_W-1:0] ns;
  } time_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_GATHER = 2'b01,
    ST_WAIT = 2'b10
  } gen_state_t;

  function automatic logic time_reached(input time_t now, input time_t tgt);
    return (now.sec > tgt.sec) || (now.sec == tgt.sec && now.ns >= tgt.ns);
  endfunction : time_reached

  function automatic time_t add_relative(input time_t ref_time,
                                         input logic [NS_W-1:0] delta);
    logic [NS_W:0] sum;
    time_t res;
    sum = {1'b0, ref_time.ns} + {1'b0, delta};
    res = ref_time;
    if (sum >= {1'b0, NS_PER_SEC})
    begin
      res.ns = NS_W'(sum - {1'b0, NS_PER_SEC});
      res.sec = ref_time.sec + 48'h1;
    end
    else
    begin
      res.ns = sum[NS_W-1:0];
    end
    return res;
  endfunction : add_relative

endpackage : time_engine_pkg

// ### rtl/cmd_fifo.sv
// command store for one event generator, with two random read ports
`timescale 1ns/100ps
module cmd_fifo
  import time_engine_pkg::*;
#(
  parameter int WIDTH = CMD_W,
  parameter int DEPTH = GEN_FIFO_DEPTH,
  parameter int PTR_W = $clog2(DEPTH)
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  input wire logic [PTR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  input wire logic [PTR_W-1:0] peek_addr,
  output logic [WIDTH-1:0] peek_data,
  output logic [PTR_W-1:0] head,
  output logic empty,
  output logic full
);

  // executed words stay in place so repeat groups can re-read them
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] head_q;
  logic [PTR_W:0] cnt_q;
  logic do_push;

  assign full = cnt_q == (PTR_W+1)'(DEPTH);
  assign empty = cnt_q == '0;
  assign do_push = push && !full;
  assign head = head_q;
  assign rd_data = mem_q[rd_addr];
  assign peek_data = mem_q[peek_addr];

  always_ff @(posedge clock)
  begin
    if (do_push)
      mem_q[wr_q] <= push_data;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_q <= '0;
      head_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      head_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + 1'b1;
      if (pop && !empty)
        head_q <= head_q + 1'b1;
      if (do_push && !(pop && !empty))
        cnt_q <= cnt_q + 1'b1;
      else if (!do_push && pop && !empty)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : cmd_fifo

// ### rtl/out_clock_gen.sv
// divided output clock built as a word of sub-cycle phase samples
`timescale 1ns/100ps
module out_clock_gen
  import time_engine_pkg::*;
#(
  parameter int DIVW = DIV_W,
  parameter int PHASES = OUT_PHASES
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [DIVW-1:0] divisor,
  input wire logic invert,
  input wire logic resync,
  output logic [PHASES-1:0] phases
);

  localparam int POS_W = DIVW + $clog2(PHASES) + 1;

  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] span;
  logic [POS_W-1:0] half;
  logic [POS_W-1:0] step;
  logic [PHASES-1:0] bits;
  logic [PHASES-1:0] phases_q;

  // a zero divisor behaves as one rather than stopping the clock
  always_comb
  begin
    logic [DIVW-1:0] n;
    n = (divisor == '0) ? DIVW'(1) : divisor;
    span = POS_W'(n) * POS_W'(PHASES);
    half = span >> 1;
  end

  always_comb
  begin
    logic [POS_W-1:0] p;
    p = '0;
    for (int k = 0; k < PHASES; k++)
    begin
      p = pos_q + POS_W'(k);
      if (p >= span)
        p = p - span;
      bits[k] = p < half;
    end
  end

  assign step = pos_q + POS_W'(PHASES);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pos_q <= '0;
    else if (resync || pos_q >= span)
      pos_q <= '0;
    else if (step >= span)
      pos_q <= step - span;
    else
      pos_q <= step;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      phases_q <= '0;
    else
      phases_q <= bits ^ {PHASES{invert}};
  end

  assign phases = phases_q;

endmodule : out_clock_gen

// ### rtl/time_engine_output_generators.sv
// output clock, two event generators and their pin routing
`timescale 1ns/100ps
module time_engine_output_generators
  import time_engine_pkg::*;
#(
  parameter int PIN_COUNT = 4,
  parameter int FIFO_DEPTH = GEN_FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire time_t now_time,
  input wire logic time_base_step,
  input wire logic [DIV_W-1:0] out_clock_divisor,
  input wire logic out_clock_invert,
  input wire logic [2*PIN_COUNT-1:0] pin_config_one,
  input wire logic [GEN_COUNT-1:0] cmd_push,
  input wire cmd_word_t cmd_data,
  output logic [GEN_COUNT-1:0] fifo_full,
  input wire logic gen1_reset_bit,
  input wire logic gen2_reset_bit,
  input wire logic gen1_hold_bit,
  input wire logic gen2_hold_bit,
  input wire logic [GEN_COUNT-1:0] done_clear,
  output logic gen1_command_done_flag,
  output logic gen2_command_done_flag,
  output logic [OUT_PHASES-1:0] time_base_clock_out,
  output logic [GEN_COUNT-1:0] gen_level,
  output logic [GEN_COUNT-1:0] gen_oe,
  output logic [PIN_COUNT-1:0][OUT_PHASES-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  logic [GEN_COUNT-1:0] gen_reset;
  logic [GEN_COUNT-1:0] gen_hold;
  logic [GEN_COUNT-1:0] done_flag;

  assign gen_reset = {gen2_reset_bit, gen1_reset_bit};
  assign gen_hold = {gen2_hold_bit, gen1_hold_bit};
  assign gen1_command_done_flag = done_flag[0];
  assign gen2_command_done_flag = done_flag[1];

  // time_base_step marks a direct write or step of the time base
  out_clock_gen #(
    .DIVW(DIV_W),
    .PHASES(OUT_PHASES)
  ) u_clk (
    .clock(clock),
    .rst_b(rst_b),
    .divisor(out_clock_divisor),
    .invert(out_clock_invert),
    .resync(time_base_step),
    .phases(time_base_clock_out)
  );

  for (genvar g = 0; g < GEN_COUNT; g++)
  begin : gen_evt
    logic [CMD_W-1:0] rd_raw;
    logic [CMD_W-1:0] peek_raw;
    cmd_word_t word;
    cmd_word_t peek;
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] rd_addr;
    logic [PTR_W-1:0] peek_addr;
    logic empty;
    logic full;
    gen_state_t st_q;
    cmd_word_t cmd_q;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [2:0] words_q;
    logic [2:0] words_d;
    logic [2:0] need;
    logic [3:0] cur_code;
    time_t tgt_q;
    time_t ref_q;
    time_t target;
    logic lvl_q;
    logic oe_q;
    logic [HIZ_CNT_W-1:0] hiz_q;
    logic loop_q;
    logic frac_q;
    logic seg_q;
    logic lstat_q;
    logic [PTR_W-1:0] cur_q;
    logic [PTR_W-1:0] base_q;
    logic [PTR_W-1:0] end_q;
    logic [REP_M_W-1:0] rem_q;
    logic [FRAC_M_W:0] seg_rem_q;
    logic [FRAC_M_W:0] m1_q;
    logic [FRAC_M_W:0] m2_q;
    logic [FRAC_M_W:0] m1_in;
    logic [FRAC_M_W:0] m2_in;
    logic [REP_N_W-1:0] rep_n;
    logic at_mid;
    logic at_end;
    logic boundary;
    logic take;
    logic first;
    logic is_edge;
    logic last;
    logic fire;
    logic start_rep;
    logic start_frac;
    logic exit_loop;
    logic done_set;

    cmd_fifo #(
      .WIDTH(CMD_W),
      .DEPTH(FIFO_DEPTH),
      .PTR_W(PTR_W)
    ) u_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .flush(gen_reset[g]),
      .push(cmd_push[g]),
      .push_data(cmd_data),
      .pop(take && !loop_q),
      .rd_addr(rd_addr),
      .rd_data(rd_raw),
      .peek_addr(peek_addr),
      .peek_data(peek_raw),
      .head(head),
      .empty(empty),
      .full(full)
    );

    assign word = cmd_word_t'(rd_raw);
    assign peek = cmd_word_t'(peek_raw);
    assign fifo_full[g] = full;
    assign rd_addr = loop_q ? cur_q : head;
    assign peek_addr = head - PTR_W'(FRAC_SPAN);
    assign rep_n = word.data[REP_N_LSB +: REP_N_W];

    // a 32-bit entry pair counts one toggle per pass, a 16-bit pair two
    assign m1_in = (peek.code[1:0] == FORM_REL32) ?
      {word.data[FRAC_M1_LSB +: FRAC_M_W], 1'b0} :
      {1'b0, word.data[FRAC_M1_LSB +: FRAC_M_W]};
    assign m2_in = (peek.code[1:0] == FORM_REL32) ?
      {word.data[FRAC_M2_LSB +: FRAC_M_W], 1'b0} :
      {1'b0, word.data[FRAC_M2_LSB +: FRAC_M_W]};

    assign at_mid = loop_q && frac_q && !seg_q &&
      cur_q == base_q + PTR_W'(FRAC_HALF);
    assign at_end = loop_q && cur_q == end_q;
    assign boundary = st_q == ST_FETCH && (at_end || at_mid);
    assign take = st_q != ST_WAIT && !boundary && (loop_q ||
      (!empty && !(gen_hold[g] && st_q == ST_FETCH)));
    assign first = take && st_q == ST_FETCH;

    assign cur_code = (st_q == ST_FETCH) ? word.code : cmd_q.code;
    assign is_edge = cur_code[3:2] != EDGE_NONE &&
      cur_code[1:0] != FORM_NONE;
    assign need = (cur_code[1:0] == FORM_ABS) ? WORDS_ABS :
      (cur_code[1:0] == FORM_REL32) ? WORDS_REL32 : WORDS_REL16;
    assign acc_d = (st_q == ST_FETCH) ?
      {{(ACC_W-DATA_W){1'b0}}, word.data} :
      {acc_q[ACC_W-DATA_W-1:0], word.data};
    assign words_d = (st_q == ST_FETCH) ? 3'h1 : words_q + 3'h1;
    assign last = take && is_edge && words_d == need;

    always_comb
    begin
      target = add_relative(ref_q, NS_W'(acc_d[DATA_W-1:0]));
      if (cur_code[1:0] == FORM_ABS)
      begin
        target.sec = acc_d[ACC_W-1:2*DATA_W];
        target.ns = acc_d[NS_W-1:0];
      end
      else if (cur_code[1:0] == FORM_REL32)
        target = add_relative(ref_q, acc_d[NS_W-1:0]);
    end

    assign fire = st_q == ST_WAIT && time_reached(now_time, tgt_q);
    assign start_rep = first && !loop_q && word.code == CODE_REPEAT &&
      rep_n != '0;
    assign start_frac = first && !loop_q && word.code == CODE_FRAC &&
      (m1_in != '0 || m2_in != '0);
    // an endless group gives way only to a new word with hold released
    assign exit_loop = boundary && at_end && ((!empty && !gen_hold[g] &&
      (frac_q || rem_q == '0)) || (!frac_q && rem_q == REP_M_W'(1)));
    assign done_set = (fire && cmd_q.stat) || (exit_loop && lstat_q) ||
      (first && !is_edge && !start_rep && !start_frac && word.stat);

    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        loop_q <= 1'b0;
        frac_q <= 1'b0;
        seg_q <= 1'b0;
        lstat_q <= 1'b0;
        cur_q <= '0;
        base_q <= '0;
        end_q <= '0;
        rem_q <= '0;
        seg_rem_q <= '0;
        m1_q <= '0;
        m2_q <= '0;
      end
      else if (gen_reset[g])
      begin
        loop_q <= 1'b0;
        frac_q <= 1'b0;
        seg_q <= 1'b0;
      end
      else if (start_rep)
      begin
        loop_q <= 1'b1;
        frac_q <= 1'b0;
        lstat_q <= word.stat;
        base_q <= head - PTR_W'(rep_n);
        cur_q <= head - PTR_W'(rep_n);
        end_q <= head;
        rem_q <= word.data[REP_M_LSB +: REP_M_W];
      end
      else if (start_frac)
      begin
        loop_q <= 1'b1;
        frac_q <= 1'b1;
        lstat_q <= word.stat;
        base_q <= head - PTR_W'(FRAC_SPAN);
        end_q <= head;
        m1_q <= m1_in;
        m2_q <= m2_in;
        seg_q <= m1_in == '0;
        seg_rem_q <= (m1_in == '0) ? m2_in : m1_in;
        cur_q <= head - PTR_W'((m1_in == '0) ? FRAC_HALF : FRAC_SPAN);
      end
      else if (take && loop_q)
        cur_q <= cur_q + 1'b1;
      else if (exit_loop)
        loop_q <= 1'b0;
      else if (boundary && !frac_q)
      begin
        if (rem_q != '0)
          rem_q <= rem_q - 1'b1;
        cur_q <= base_q;
      end
      else if (boundary && (at_mid || seg_q) && seg_rem_q > 9'h1)
      begin
        seg_rem_q <= seg_rem_q - 1'b1;
        cur_q <= at_mid ? base_q : base_q + PTR_W'(FRAC_HALF);
      end
      else if (boundary && ((at_mid && m2_q != '0) || m1_q == '0))
      begin
        seg_q <= 1'b1;
        seg_rem_q <= m2_q;
        cur_q <= base_q + PTR_W'(FRAC_HALF);
      end
      else if (boundary)
      begin
        seg_q <= 1'b0;
        seg_rem_q <= m1_q;
        cur_q <= base_q;
      end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        st_q <= ST_FETCH;
        cmd_q <= '0;
        acc_q <= '0;
        words_q <= '0;
        tgt_q <= '0;
        ref_q <= '0;
      end
      else if (gen_reset[g])
        st_q <= ST_FETCH;
      else
      begin
        unique case (st_q)
          ST_FETCH:
          begin
            if (first)
            begin
              cmd_q <= word;
              acc_q <= acc_d;
              words_q <= words_d;
              if (last)
              begin
                tgt_q <= target;
                st_q <= ST_WAIT;
              end
              else if (is_edge)
                st_q <= ST_GATHER;
              else if (word.code == CODE_REF)
                ref_q <= now_time;
            end
          end
          ST_GATHER:
          begin
            if (take)
            begin
              acc_q <= acc_d;
              words_q <= words_d;
              if (last)
              begin
                tgt_q <= target;
                st_q <= ST_WAIT;
              end
            end
          end
          ST_WAIT:
          begin
            if (fire)
            begin
              ref_q <= tgt_q;
              st_q <= ST_FETCH;
            end
          end
          default:
            st_q <= ST_FETCH;
        endcase
      end
    end

    // events land on whole clock cycles; sub-cycle placement is the clock's
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
      begin
        lvl_q <= 1'b0;
        oe_q <= 1'b1;
        hiz_q <= '0;
      end
      else if (gen_reset[g])
      begin
        lvl_q <= 1'b0;
        oe_q <= 1'b1;
        hiz_q <= '0;
      end
      else if (fire)
      begin
        oe_q <= 1'b1;
        hiz_q <= cmd_q.hiz ? HIZ_CNT_W'(HIZ_DELAY_CYCLES) : '0;
        if (cmd_q.code[3:2] == EDGE_RISE)
          lvl_q <= 1'b1;
        else if (cmd_q.code[3:2] == EDGE_FALL)
          lvl_q <= 1'b0;
        else
          lvl_q <= !lvl_q;
      end
      else if (hiz_q != '0)
      begin
        hiz_q <= hiz_q - 1'b1;
        if (hiz_q == HIZ_CNT_W'(1))
          oe_q <= 1'b0;
      end
    end

    // a completion in the same cycle as a clear keeps the flag set
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
        done_flag[g] <= 1'b0;
      else if (done_set)
        done_flag[g] <= 1'b1;
      else if (done_clear[g])
        done_flag[g] <= 1'b0;
    end

    assign gen_level[g] = lvl_q;
    assign gen_oe[g] = oe_q;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      for (int p = 0; p < PIN_COUNT; p++)
      begin
        unique case (pin_config_one[2*p +: 2])
          SRC_CLOCK:
          begin
            pin_out[p] <= time_base_clock_out;
            pin_oe[p] <= 1'b1;
          end
          SRC_GEN1:
          begin
            pin_out[p] <= {OUT_PHASES{gen_level[0]}};
            pin_oe[p] <= gen_oe[0];
          end
          SRC_GEN2:
          begin
            pin_out[p] <= {OUT_PHASES{gen_level[1]}};
            pin_oe[p] <= gen_oe[1];
          end
          SRC_OFF:
          begin
            pin_out[p] <= '0;
            pin_oe[p] <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : time_engine_output_generators

// ### verification/time_engine_output_generators_sva.sv
// port assertions for the time engine output generators
`timescale 1ns/100ps
module time_engine_output_generators_sva
  import time_engine_pkg::*;
#(
  parameter int PIN_COUNT = 4
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic time_base_step,
  input wire logic [DIV_W-1:0] out_clock_divisor,
  input wire logic out_clock_invert,
  input wire logic [2*PIN_COUNT-1:0] pin_config_one,
  input wire logic [GEN_COUNT-1:0] cmd_push,
  input wire logic [GEN_COUNT-1:0] fifo_full,
  input wire logic gen1_reset_bit,
  input wire logic gen2_reset_bit,
  input wire logic [GEN_COUNT-1:0] done_clear,
  input wire logic gen1_command_done_flag,
  input wire logic [OUT_PHASES-1:0] time_base_clock_out,
  input wire logic [GEN_COUNT-1:0] gen_level,
  input wire logic [GEN_COUNT-1:0] gen_oe,
  input wire logic [PIN_COUNT-1:0] pin_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  chk_gen_one_reset:
    assert property (gen1_reset_bit |=> !gen_level[0] && gen_oe[0]
      && !fifo_full[0]) else $error("gen1 reset left state");
  chk_gen_two_reset:
    assert property (gen2_reset_bit |=> !gen_level[1] && gen_oe[1]
      && !fifo_full[1]) else $error("gen2 reset left state");
  chk_div_one_word:
    assert property ((out_clock_divisor == 8'h01 && !out_clock_invert)[*3]
      |-> time_base_clock_out == 8'h0F) else $error("divide by one");
  chk_div_one_inv:
    assert property ((out_clock_divisor == 8'h01 && out_clock_invert)[*3]
      |-> time_base_clock_out == 8'hF0) else $error("inverted word");
  chk_div_two_alt:
    assert property ((out_clock_divisor == 8'h02 && !time_base_step
      && $stable(out_clock_invert))[*4] |-> time_base_clock_out inside
      {8'hFF, 8'h00} && time_base_clock_out != $past(time_base_clock_out))
      else $error("divide by two");
  chk_pin_off_quiet:
    assert property ((pin_config_one[1:0] == SRC_OFF)[*2] |-> !pin_oe[0])
      else $error("unrouted pin driven");
  chk_pin_clock_on:
    assert property ((pin_config_one[1:0] == SRC_CLOCK)[*2] |-> pin_oe[0])
      else $error("clock pin not driven");
  chk_done_flag_sticky:
    assert property (gen1_command_done_flag && !done_clear[0]
      && !gen1_reset_bit |=> gen1_command_done_flag)
      else $error("done flag dropped");
  chk_full_after_push:
    assert property ($rose(fifo_full[0]) |-> $past(cmd_push[0]))
      else $error("full without push");
endmodule : time_engine_output_generators_sva

bind time_engine_output_generators time_engine_output_generators_sva
  #(.PIN_COUNT(PIN_COUNT)) chk (.clock(clock), .rst_b(rst_b),
  .time_base_step(time_base_step), .out_clock_divisor(out_clock_divisor),
  .out_clock_invert(out_clock_invert), .pin_config_one(pin_config_one),
  .cmd_push(cmd_push), .fifo_full(fifo_full),
  .gen1_reset_bit(gen1_reset_bit), .gen2_reset_bit(gen2_reset_bit),
  .done_clear(done_clear), .gen1_command_done_flag(gen1_command_done_flag),
  .time_base_clock_out(time_base_clock_out), .gen_level(gen_level),
  .gen_oe(gen_oe), .pin_oe(pin_oe));

// ### verification/time_base_model.sv
// time base partner: one clock period per edge, restart pulse on request
`timescale 1ns/100ps
module time_base_model
  import time_engine_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic jump,
  output time_t now_time,
  output logic step
);
  // no second rollover: runs stay far below one second
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      now_time <= '{sec: 48'h1, ns: 30'h0};
      step <= 1'b0;
    end
    else
    begin
      step <= jump;
      now_time.ns <= now_time.ns + NS_W'(CLK_PERIOD_NS);
    end
  end
endmodule : time_base_model

// ### verification/time_engine_output_generators_tb.sv
// self-checking bench for the time engine output generators
`timescale 1ns/100ps
module time_engine_output_generators_tb
  import time_engine_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic jump = 1'b0;
  logic step;
  time_t now_time;
  logic [7:0] divisor = 8'h01;
  logic invert = 1'b0;
  logic [7:0] pin_cfg = 8'h39;
  logic [1:0] push = 2'h0;
  logic [21:0] cmd = 22'h0;
  logic [1:0] full;
  logic [1:0] grst = 2'h0;
  logic [1:0] ghold = 2'h0;
  logic [1:0] dclr = 2'h0;
  logic [1:0] done;
  logic [7:0] cword;
  logic [1:0] lvl;
  logic [1:0] oe;
  logic [3:0] poe;
  logic [3:0][7:0] pout;
  logic [7:0] wq [0:1][0:509];
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'hAA9E;

  always #25 clock = ~clock;

  time_base_model partner (.clock(clock), .rst_b(rst_b), .jump(jump),
    .now_time(now_time), .step(step));
  time_engine_output_generators dut (.clock(clock), .rst_b(rst_b),
    .now_time(now_time), .time_base_step(step), .out_clock_divisor(divisor),
    .out_clock_invert(invert), .pin_config_one(pin_cfg), .cmd_push(push),
    .cmd_data(cmd), .fifo_full(full), .gen1_reset_bit(grst[0]),
    .gen2_reset_bit(grst[1]), .gen1_hold_bit(ghold[0]),
    .gen2_hold_bit(ghold[1]), .done_clear(dclr),
    .gen1_command_done_flag(done[0]), .gen2_command_done_flag(done[1]),
    .time_base_clock_out(cword), .gen_level(lvl), .gen_oe(oe),
    .pin_out(pout), .pin_oe(poe));

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [21:0] cw(input logic [1:0] x,
                                     input logic [3:0] c,
                                     input logic [15:0] d);
    return {x, c, d};
  endfunction : cw

  function automatic logic [3:0] pin_on(input logic [7:0] cfg);
    logic [3:0] r;
    for (int p = 0; p < 4; p++)
      r[p] = cfg[2*p +: 2] != SRC_OFF;
    return r;
  endfunction : pin_on

  task automatic put(input int g, input logic [21:0] w);
    @(posedge clock);
    cmd <= w;
    push[g] <= 1'b1;
    @(posedge clock);
    push[g] <= 1'b0;
  endtask : put

  task automatic hold(input int g, input logic v);
    @(posedge clock);
    ghold[g] <= v;
  endtask : hold

  task automatic wait_for(input int g, input bit use_oe, input logic v,
                          input int lim, output int n);
    n = 0;
    @(negedge clock);
    while ((use_oe ? oe[g] : lvl[g]) !== v && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= lim)
    begin
      check(32'h0, 32'h1);
      close_out();
    end
  endtask : wait_for

  task automatic edges(input int g, input int cyc, output int c);
    logic last;
    c = 0;
    @(negedge clock);
    last = lvl[g];
    repeat (cyc)
    begin
      @(negedge clock);
      c += (lvl[g] !== last);
      last = lvl[g];
    end
  endtask : edges

  task automatic grab(input logic [7:0] n, input logic iv);
    @(posedge clock);
    divisor <= n;
    invert <= iv;
    jump <= 1'b1;
    @(posedge clock);
    jump <= 1'b0;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 2 * n; k++)
    begin
      @(negedge clock);
      wq[iv][k] = cword;
    end
  endtask : grab

  initial
  begin
    int n, k, c, ones, bad, flips;
    logic [7:0] nn;
    logic [7:0] cw_prev;
    time_t t;
    repeat (15) @(negedge clock);
    check({lvl, oe, poe, full, done}, {2'h0, 2'h3, 4'h0, 2'h0, 2'h0});
    @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      nn = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : (i == 2) ? 8'h02
        : 8'($random(seed));
      nn = (nn == 8'h00) ? 8'h03 : nn;
      grab(nn, 1'b0);
      grab(nn, 1'b1);
      ones = 0;
      bad = 0;
      flips = 0;
      for (int j = 0; j < nn; j++)
      begin
        ones += $countones(wq[0][j]);
        bad += (wq[0][j] !== wq[0][j + nn]);
        flips += (wq[1][j] !== ~wq[0][j]);
      end
      check(ones, 4 * nn);
      check(bad, 0);
      check(flips, 0);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      pin_cfg <= (i == 0) ? 8'h39 : (i == 1) ? 8'h6C : 8'($random(seed));
      repeat (2) @(negedge clock);
      cw_prev = cword;
      @(negedge clock);
      check(poe, pin_on(pin_cfg));
      for (int p = 0; p < 4; p++)
        check(pout[p], (pin_cfg[2*p +: 2] == SRC_CLOCK) ?
          cw_prev : 8'h00);
    end
    for (int g = 0; g < 2; g++)
    begin
      k = 10 + ($unsigned($random(seed)) % 20);
      hold(g, 1'b1);
      put(g, 22'h020000);
      put(g, cw(2'h0, 4'h7, 16'(50 * k)));
      repeat (2 * k) @(negedge clock);
      check(lvl, 2'h0);
      hold(g, 1'b0);
      wait_for(g, 0, 1'b1, 100, n);
      check(n inside {[k - 4 : k + 5]}, 1);
      check(lvl[1 - g], 0);
      check(done[g], 0);
      put(g, cw(2'h2, 4'hB, 16'(50 * k)));
      wait_for(g, 0, 1'b0, 100, n);
      check(n inside {[k - 6 : k + 3]}, 1);
      repeat (2) @(negedge clock);
      check(done[g], 1);
      @(posedge clock);
      dclr[g] <= 1'b1;
      @(posedge clock);
      dclr[g] <= 1'b0;
      @(negedge clock);
      check(done[g], 0);
      for (int u = 0; u < 4; u++)
        put(g, cw(2'h0, (u == 0) ? 4'h3 : 4'(u << 2), 16'h0001));
      repeat (8) @(negedge clock);
      check({lvl[g], oe[g]}, 2'h1);
      put(g, 22'h020000);
      put(g, cw(2'h1, 4'hF, 16'(50 * k)));
      wait_for(g, 0, 1'b1, 100, n);
      wait_for(g, 1, 1'b0, 3, n);
      @(negedge clock);
      t = now_time;
      t.ns = t.ns + 30'(50 * (k + 12));
      put(g, cw(2'h0, 4'h9, t.sec[47:32]));
      put(g, cw(2'h0, 4'hF, t.sec[31:16]));
      put(g, cw(2'h0, 4'h3, t.sec[15:0]));
      put(g, cw(2'h0, 4'h0, {2'h0, t.ns[29:16]}));
      put(g, cw(2'h0, 4'h7, t.ns[15:0]));
      wait_for(g, 0, 1'b0, 100, n);
      check(n inside {[k - 3 : k + 5]}, 1);
      check(oe[g], 1);
      put(g, cw(2'h0, 4'h6, 16'h0001));
      put(g, cw(2'h0, 4'h6, 16'h0000));
      wait_for(g, 0, 1'b1, 1500, n);
      check(n inside {[1298 : 1314]}, 1);
      hold(g, 1'b1);
      put(g, 22'h020000);
      put(g, cw(2'h0, 4'hF, 16'h00C8));
      put(g, 22'h000001);
      hold(g, 1'b0);
      edges(g, 80, c);
      check(c inside {[18 : 21]}, 1);
      put(g, 22'h020000);
      repeat (10) @(negedge clock);
      edges(g, 40, c);
      check(c, 0);
      hold(g, 1'b1);
      put(g, 22'h020000);
      for (int e = 0; e < 4; e++)
        put(g, cw(2'h0, 4'hF, (e < 2) ? 16'h00C8 : 16'h0190));
      put(g, 22'h010102);
      hold(g, 1'b0);
      repeat (40) @(negedge clock);
      edges(g, 240, c);
      check(c inside {[35 : 37]}, 1);
      hold(g, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
        @(negedge clock);
        check(full[g], 0);
        put(g, 22'h020000);
      end
      @(negedge clock);
      check(full[g], 1);
      @(posedge clock);
      grst[g] <= 1'b1;
      @(posedge clock);
      grst[g] <= 1'b0;
      ghold[g] <= 1'b0;
      @(negedge clock);
      check({full[g], lvl[g], oe[g]}, 3'h1);
    end
    close_out();
  end
endmodule : time_engine_output_generators_tb
